/* nvm_cmd_defines.svh */
// Offsets, field positions, reset values and command codes of the command/status logic.
// Included by the design and the testbench; definitions only.
`ifndef NVM_CMD_DEFINES_SVH
`define NVM_CMD_DEFINES_SVH
`define NVM_ADDR_STATUS 8'h00
`define NVM_ADDR_COMMAND 8'h01
`define NVM_ADDR_CLKDIV 8'h02
`define NVM_ADDR_PROT 8'h03
`define NVM_ADDR_IRQ_STATUS 8'h04
`define NVM_ADDR_IRQ_ENABLE 8'h05
`define NVM_ADDR_IRQ_CLEAR 8'h06
`define NVM_BIT_CBEF 7
`define NVM_BIT_CCF 6
`define NVM_BIT_PVIOL 5
`define NVM_BIT_ACCERR 4
`define NVM_BIT_BLANK 2
`define NVM_CMD_BLANK 8'h05
`define NVM_CMD_BYTE_PROG 8'h20
`define NVM_CMD_BURST_PROG 8'h25
`define NVM_CMD_SECT_ERASE 8'h40
`define NVM_CMD_MASS_ERASE 8'h41
`define NVM_CMD_ERASE_ABORT 8'h47
`define NVM_RST_COMMAND 8'h00
`define NVM_RST_PROT 8'hFF
`define NVM_RST_CLKDIV 8'h00
`define NVM_IRQ_W 3
`endif

/* nvm_cmd_pkg.sv */
// Types shared by the command/status logic.
// Assumes nvm_cmd_defines.svh holds the numbers.
package nvm_cmd_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
   typedef struct packed {
      logic launch;
      logic [7:0] cmd;
      logic burst;
   } array_req_t;
   typedef struct packed {
      logic done;
      logic prot_hit;
      logic blank_ok;
   } array_rsp_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01
   } eng_state_t;
endpackage

/* nvm_command_status_logic.sv */
// Command launch and status flags of the flash/EEPROM controller.
// Assumes the array engine pulses done once per started command, same clock.
`timescale 1ns/1ps
`include "nvm_cmd_defines.svh"
module nvm_command_status_logic
   import nvm_cmd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic stop_entry,
   input wire logic seq_error,
   input wire logic prot_hit,
   input wire array_rsp_t array_rsp,
   output array_req_t array_req,
   output logic [7:0] prot_value,
   output logic irq
);
   logic cbef_ff, nxt_cbef;
   logic ccf_ff, nxt_ccf;
   logic pviol_ff, nxt_pviol;
   logic accerr_ff, nxt_accerr;
   logic blank_ff, nxt_blank;
   logic [7:0] cmd_ff, nxt_cmd;
   logic [7:0] clkdiv_ff, nxt_clkdiv;
   logic div_set_ff, nxt_div_set;
   logic [7:0] prot_ff, nxt_prot;
   eng_state_t state_ff, nxt_state;
   logic [7:0] run_cmd_ff, nxt_run_cmd;
   logic pend_ff, nxt_pend;
   logic [7:0] pend_cmd_ff, nxt_pend_cmd;
   array_req_t areq_ff, nxt_areq;
   logic [`NVM_IRQ_W-1:0] ist_ff, nxt_ist;
   logic [`NVM_IRQ_W-1:0] ien_ff, nxt_ien;
   logic irq_ff, nxt_irq;
   logic [7:0] rdata_ff, nxt_rdata;
   logic wr_stat, launch_try, legal, is_pe, rejected, accepted, busy;
   logic [`NVM_IRQ_W-1:0] ev;

   assign wr_stat = reg_req.wr && reg_req.addr == `NVM_ADDR_STATUS;
   // Writing zero to bit 7 is not a launch
   assign launch_try = wr_stat && reg_req.wdata[`NVM_BIT_CBEF] && cbef_ff;
   assign busy = state_ff == ST_BUSY;

   always_comb begin
      unique case (cmd_ff)
         `NVM_CMD_BLANK, `NVM_CMD_BYTE_PROG, `NVM_CMD_BURST_PROG: legal = 1'b1;
         `NVM_CMD_SECT_ERASE, `NVM_CMD_MASS_ERASE, `NVM_CMD_ERASE_ABORT: legal = 1'b1;
         default: legal = 1'b0;
      endcase
   end
   assign is_pe = cmd_ff != `NVM_CMD_BLANK && cmd_ff != `NVM_CMD_ERASE_ABORT;
   // Only a burst may queue behind a running burst
   assign rejected = !legal || seq_error || (is_pe && !div_set_ff) || (is_pe && prot_hit)
      || (busy && !(cmd_ff == `NVM_CMD_BURST_PROG && run_cmd_ff == `NVM_CMD_BURST_PROG));
   assign accepted = launch_try && !rejected;

   always_comb begin
      nxt_cbef = cbef_ff;
      nxt_ccf = ccf_ff;
      nxt_pviol = pviol_ff;
      nxt_accerr = accerr_ff;
      nxt_blank = blank_ff;
      nxt_cmd = cmd_ff;
      nxt_clkdiv = clkdiv_ff;
      nxt_div_set = div_set_ff;
      nxt_prot = prot_ff;
      nxt_state = state_ff;
      nxt_run_cmd = run_cmd_ff;
      nxt_pend = pend_ff;
      nxt_pend_cmd = pend_cmd_ff;
      nxt_areq = '0;
      ev = '0;
      if (reg_req.wr && reg_req.addr == `NVM_ADDR_COMMAND) begin
         nxt_cmd = reg_req.wdata;
      end
      if (reg_req.wr && reg_req.addr == `NVM_ADDR_CLKDIV) begin
         nxt_clkdiv = reg_req.wdata;
         nxt_div_set = 1'b1;
      end
      // Protected area grows as bits clear; refusing any bit set keeps it monotonic
      if (reg_req.wr && reg_req.addr == `NVM_ADDR_PROT && (reg_req.wdata & ~prot_ff) == 8'h00) begin
         nxt_prot = reg_req.wdata;
      end
      // Flag clears by write-one; hardware set below wins
      if (wr_stat && reg_req.wdata[`NVM_BIT_PVIOL]) begin
         nxt_pviol = 1'b0;
      end
      if (wr_stat && reg_req.wdata[`NVM_BIT_ACCERR]) begin
         nxt_accerr = 1'b0;
      end
      if (array_rsp.done && busy) begin
         if (run_cmd_ff == `NVM_CMD_BLANK && array_rsp.blank_ok) begin
            nxt_blank = 1'b1;
         end
         ev[0] = 1'b1;
         if (pend_ff) begin
            nxt_run_cmd = pend_cmd_ff;
            nxt_pend = 1'b0;
            nxt_cbef = 1'b1;
            nxt_areq.launch = 1'b1;
            nxt_areq.cmd = pend_cmd_ff;
            nxt_areq.burst = 1'b1;
         end else begin
            nxt_state = ST_IDLE;
         end
      end
      if (launch_try) begin
         nxt_cbef = 1'b0;
         if (!accepted) begin
            nxt_cbef = 1'b1;
            if (legal && !seq_error && is_pe && prot_hit && div_set_ff) begin
               nxt_pviol = 1'b1;
               ev[1] = 1'b1;
            end else begin
               nxt_accerr = 1'b1;
               ev[2] = 1'b1;
            end
         end else if (busy && !(array_rsp.done && !pend_ff)) begin
            // Burst waits in the one-deep buffer; buffer-empty stays low until it moves
            nxt_pend = 1'b1;
            nxt_pend_cmd = cmd_ff;
            nxt_blank = 1'b0;
            nxt_ccf = 1'b0;
         end else begin
            nxt_state = ST_BUSY;
            nxt_run_cmd = cmd_ff;
            nxt_cbef = 1'b1;
            nxt_ccf = 1'b0;
            nxt_blank = 1'b0;
            nxt_areq.launch = 1'b1;
            nxt_areq.cmd = cmd_ff;
            nxt_areq.burst = cmd_ff == `NVM_CMD_BURST_PROG;
         end
      end
      if (stop_entry && busy) begin
         nxt_accerr = 1'b1;
         ev[2] = 1'b1;
      end
      if (nxt_state == ST_IDLE && !nxt_pend && nxt_cbef && !nxt_areq.launch) begin
         nxt_ccf = 1'b1;
      end else begin
         nxt_ccf = 1'b0;
      end
   end

   always_comb begin
      nxt_ien = ien_ff;
      nxt_ist = ist_ff;
      if (reg_req.wr && reg_req.addr == `NVM_ADDR_IRQ_ENABLE) begin
         nxt_ien = reg_req.wdata[`NVM_IRQ_W-1:0];
      end
      if (reg_req.wr && reg_req.addr == `NVM_ADDR_IRQ_CLEAR) begin
         nxt_ist = ist_ff & ~reg_req.wdata[`NVM_IRQ_W-1:0];
      end
      nxt_ist = nxt_ist | ev;
      nxt_irq = |(nxt_ist & nxt_ien);
   end

   always_comb begin
      nxt_rdata = 8'h00;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `NVM_ADDR_STATUS: begin
               nxt_rdata[`NVM_BIT_CBEF] = cbef_ff;
               nxt_rdata[`NVM_BIT_CCF] = ccf_ff;
               nxt_rdata[`NVM_BIT_PVIOL] = pviol_ff;
               nxt_rdata[`NVM_BIT_ACCERR] = accerr_ff;
               nxt_rdata[`NVM_BIT_BLANK] = blank_ff;
            end
            `NVM_ADDR_COMMAND: nxt_rdata = cmd_ff;
            `NVM_ADDR_CLKDIV: nxt_rdata = clkdiv_ff;
            `NVM_ADDR_PROT: nxt_rdata = prot_ff;
            `NVM_ADDR_IRQ_STATUS: nxt_rdata = {5'h00, ist_ff};
            `NVM_ADDR_IRQ_ENABLE: nxt_rdata = {5'h00, ien_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cbef_ff <= 1'b1;
         ccf_ff <= 1'b1;
         pviol_ff <= 1'b0;
         accerr_ff <= 1'b0;
         blank_ff <= 1'b0;
         cmd_ff <= `NVM_RST_COMMAND;
         clkdiv_ff <= `NVM_RST_CLKDIV;
         div_set_ff <= 1'b0;
         prot_ff <= `NVM_RST_PROT;
         state_ff <= ST_IDLE;
         run_cmd_ff <= 8'h00;
         pend_ff <= 1'b0;
         pend_cmd_ff <= 8'h00;
         areq_ff <= '0;
         ist_ff <= '0;
         ien_ff <= '0;
         irq_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         cbef_ff <= nxt_cbef;
         ccf_ff <= nxt_ccf;
         pviol_ff <= nxt_pviol;
         accerr_ff <= nxt_accerr;
         blank_ff <= nxt_blank;
         cmd_ff <= nxt_cmd;
         clkdiv_ff <= nxt_clkdiv;
         div_set_ff <= nxt_div_set;
         prot_ff <= nxt_prot;
         state_ff <= nxt_state;
         run_cmd_ff <= nxt_run_cmd;
         pend_ff <= nxt_pend;
         pend_cmd_ff <= nxt_pend_cmd;
         areq_ff <= nxt_areq;
         ist_ff <= nxt_ist;
         ien_ff <= nxt_ien;
         irq_ff <= nxt_irq;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;
   assign array_req = areq_ff;
   assign prot_value = prot_ff;
   assign irq = irq_ff;

   a_launch_clears_ccf: assert property (@(posedge clk_sys) disable iff (!nrst)
      accepted && !busy |=> !ccf_ff && array_req.launch)
      else $error("accepted launch did not start command");
   a_bad_code_err: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch_try && !legal |=> accerr_ff && !array_req.launch)
      else $error("illegal code not flagged");
   a_pviol_set: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch_try && legal && !seq_error && is_pe && prot_hit && div_set_ff |=> pviol_ff)
      else $error("protection violation missed");
   a_pviol_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
      pviol_ff && !(wr_stat && reg_req.wdata[`NVM_BIT_PVIOL]) |=> pviol_ff)
      else $error("violation flag dropped");
   a_accerr_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
      stop_entry && busy |=> accerr_ff)
      else $error("stop during command not flagged");
   a_nodiv_err: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch_try && legal && is_pe && !div_set_ff |=> accerr_ff && !array_req.launch)
      else $error("program before divider not flagged");
   a_ccf_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      ccf_ff |-> state_ff == ST_IDLE && cbef_ff && !pend_ff)
      else $error("complete set while busy");
   a_zero_no_launch: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_stat && !reg_req.wdata[`NVM_BIT_CBEF] && !busy |=> !array_req.launch)
      else $error("zero write launched");
   a_blank_done: assert property (@(posedge clk_sys) disable iff (!nrst)
      array_rsp.done && busy && run_cmd_ff == `NVM_CMD_BLANK && array_rsp.blank_ok
      && !launch_try |=> blank_ff)
      else $error("blank flag not set");
   a_prot_grow: assert property (@(posedge clk_sys) disable iff (!nrst)
      (prot_ff & ~$past(prot_ff)) == 8'h00)
      else $error("protection shrank");
   c_burst_queue: cover property (@(posedge clk_sys) disable iff (!nrst) nxt_pend && !pend_ff);
   c_blank_ok: cover property (@(posedge clk_sys) disable iff (!nrst) !blank_ff ##1 blank_ff);
   c_irq: cover property (@(posedge clk_sys) disable iff (!nrst) !irq_ff ##1 irq_ff);
   c_pviol_hit: cover property (@(posedge clk_sys) disable iff (!nrst) !pviol_ff ##1 pviol_ff);
   c_stop_err: cover property (@(posedge clk_sys) disable iff (!nrst) stop_entry && busy);

   a_reject_cbef_back: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch_try && !accepted
      |=> cbef_ff && !array_req.launch)
      else $error("rejected launch left buffer flag low");

   a_zero_keeps_cbef: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_stat && !reg_req.wdata[`NVM_BIT_CBEF] && !array_rsp.done
      |=> cbef_ff == $past(cbef_ff))
      else $error("zero write changed buffer flag");

   a_queue_holds_cbef: assert property (@(posedge clk_sys) disable iff (!nrst)
      pend_ff
      |-> !cbef_ff)
      else $error("buffer flag high while buffer full");

   a_queue_moves: assert property (@(posedge clk_sys) disable iff (!nrst)
      array_rsp.done && busy && pend_ff
      |=> array_req.launch && array_req.burst && cbef_ff)
      else $error("queued burst did not move to array");

   a_queue_burst_only: assert property (@(posedge clk_sys) disable iff (!nrst)
      pend_ff
      |-> pend_cmd_ff == `NVM_CMD_BURST_PROG)
      else $error("non-burst command buffered");

   a_ccf_low_busy: assert property (@(posedge clk_sys) disable iff (!nrst)
      busy && !array_rsp.done
      |=> !ccf_ff)
      else $error("complete flag set while command runs");

   a_ccf_sets_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      !busy && !launch_try
      |=> ccf_ff)
      else $error("complete flag not set when idle");

   a_pviol_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_stat && reg_req.wdata[`NVM_BIT_PVIOL] && !launch_try
      |=> !pviol_ff)
      else $error("violation flag not cleared by write one");

   a_accerr_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_stat && reg_req.wdata[`NVM_BIT_ACCERR] && !launch_try && !(stop_entry && busy)
      |=> !accerr_ff)
      else $error("access error not cleared by write one");

   a_accerr_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
      accerr_ff && !(wr_stat && reg_req.wdata[`NVM_BIT_ACCERR])
      |=> accerr_ff)
      else $error("access error dropped without write one");

   a_seq_err: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch_try && seq_error
      |=> accerr_ff && !array_req.launch)
      else $error("broken sequence not flagged");

   a_pviol_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch_try && prot_hit && is_pe
      |=> !array_req.launch)
      else $error("protected command reached array");

   a_blank_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      accepted
      |=> !blank_ff)
      else $error("blank flag kept over new command");

   a_blank_write_none: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_stat && !launch_try && !(array_rsp.done && busy)
      |=> blank_ff == $past(blank_ff))
      else $error("direct write changed blank flag");

   a_plain_codes_run: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch_try && legal && !seq_error && !is_pe && !busy
      |=> array_req.launch && array_req.cmd == $past(cmd_ff))
      else $error("blank check or abort not started");

   a_pe_codes_run: assert property (@(posedge clk_sys) disable iff (!nrst)
      launch_try && legal && !seq_error && div_set_ff && !prot_hit && !busy
      |=> array_req.launch && array_req.cmd == $past(cmd_ff))
      else $error("legal program or erase not started");

   a_burst_mark: assert property (@(posedge clk_sys) disable iff (!nrst)
      array_req.launch
      |-> array_req.burst == (array_req.cmd == `NVM_CMD_BURST_PROG))
      else $error("burst mark wrong on launch");

   a_prot_refuse: assert property (@(posedge clk_sys) disable iff (!nrst)
      reg_req.wr && reg_req.addr == `NVM_ADDR_PROT && (reg_req.wdata & ~prot_ff) != 8'h00
      |=> prot_ff == $past(prot_ff))
      else $error("shrinking protection write taken");

   a_stop_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      stop_entry && !busy && !launch_try && !(wr_stat && reg_req.wdata[`NVM_BIT_ACCERR])
      |=> accerr_ff == $past(accerr_ff))
      else $error("stop while idle changed access error");
endmodule

/* nvm_command_status_logic_tb.sv */
// Self-checking bench of the command/status logic against a queue model.
// Assumes the package and the defines header are compiled first.
`timescale 1ns/1ps
`include "nvm_cmd_defines.svh"
module nvm_command_status_logic_tb import nvm_cmd_pkg::*;;
   logic clk_sys, nrst, stop_entry, seq_error, prot_hit, irq;
   reg_req_t reg_req;
   array_rsp_t array_rsp;
   array_req_t array_req;
   logic [7:0] reg_rdata, prot_value, c;
   logic [7:0] codes [6] = '{`NVM_CMD_BLANK, `NVM_CMD_BYTE_PROG, `NVM_CMD_BURST_PROG,
      `NVM_CMD_SECT_ERASE, `NVM_CMD_MASS_ERASE, `NVM_CMD_ERASE_ABORT};
   int fails, checks, seed, m_acc, m_pv, m_blank, m_div, m_irq, m_en, m_prot;
   int m_q[$];
   nvm_command_status_logic u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .stop_entry(stop_entry), .seq_error(seq_error),
      .prot_hit(prot_hit), .array_rsp(array_rsp), .array_req(array_req),
      .prot_value(prot_value), .irq(irq));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic complete_run();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, int e);
      @(posedge clk_sys);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1;
      chk(reg_rdata, 8'(e));
   endtask
   function automatic int m_stat();
      return (int'(m_q.size() < 2) << 7) | (int'(m_q.size() == 0) << 6) | (m_pv << 5)
         | (m_acc << 4) | (m_blank << 2);
   endfunction
   // Status, event flags and the level interrupt seen together
   task automatic st();
      rd(`NVM_ADDR_STATUS, m_stat());
      rd(`NVM_ADDR_IRQ_STATUS, m_irq);
      chk({7'h00, irq}, {7'h00, (m_irq & m_en) != 0});
   endtask
   // Launch pulse is one cycle wide, so every cycle of the window is looked at
   task automatic see(int e);
      int seen;
      seen = -1;
      for (int i = 0; i < 4; i++) begin
         #1;
         if (array_req.launch === 1'b1) seen = array_req.cmd;
         @(posedge clk_sys);
      end
      chk(8'(seen), 8'(e));
      if (e >= 0 && seen < 0) complete_run();
   endtask
   task automatic done(logic bok);
      int k;
      k = m_q.pop_front();
      @(posedge clk_sys);
      array_rsp <= '{done: 1'b1, prot_hit: 1'b0, blank_ok: bok};
      @(posedge clk_sys);
      array_rsp <= '0;
      if (k == 8'h05) m_blank = bok;
      m_irq |= 1;
   endtask
   task automatic run(logic [7:0] cmd, logic ph, logic se);
      logic pe, ok;
      pe = cmd inside {8'h20, 8'h25, 8'h40, 8'h41};
      ok = 1'b0;
      wr(`NVM_ADDR_COMMAND, cmd);
      prot_hit <= ph;
      seq_error <= se;
      wr(`NVM_ADDR_STATUS, 8'h80);
      prot_hit <= 1'b0;
      seq_error <= 1'b0;
      if (!(pe || cmd inside {8'h05, 8'h47}) || se || (pe && m_div == 0)) begin
         m_acc = 1;
         m_irq |= 4;
      end else if (pe && ph) begin
         m_pv = 1;
         m_irq |= 2;
      end else begin
         ok = 1'b1;
         m_blank = 0;
         m_q.push_back(cmd);
      end
      see((ok && m_q.size() == 1) ? int'(cmd) : -1);
      st();
   endtask
   initial begin
      #200000;
      fails++;
      complete_run();
   end
   initial begin
      {fails, checks, m_acc, m_pv, m_blank, m_div, m_irq, m_en} = '0;
      seed = 67733;
      m_prot = 8'hFF;
      nrst = 1'b0;
      reg_req = '0;
      array_rsp = '0;
      {stop_entry, seq_error, prot_hit} = 3'b000;
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      st();
      rd(`NVM_ADDR_PROT, 8'hFF);
      rd(8'h07, 0);
      wr(`NVM_ADDR_IRQ_ENABLE, 8'h07);
      m_en = 7;
      // First pass before the divider is set, second after
      for (int p = 0; p < 2; p++) begin
         foreach (codes[k]) begin
            run(codes[k], 1'b0, 1'b0);
            if (m_q.size() > 0) begin
               done(1'($random(seed)));
               st();
            end
         end
         wr(`NVM_ADDR_CLKDIV, 8'($random(seed)));
         m_div = 1;
      end
      wr(`NVM_ADDR_STATUS, 8'h00);
      st();
      wr(`NVM_ADDR_STATUS, 8'h54);
      m_acc = 0;
      st();
      do c = 8'($random(seed)); while (c inside {codes, 8'hFF});
      run(c, 1'b0, 1'b0);
      run(`NVM_CMD_SECT_ERASE, 1'b1, 1'b0);
      run(`NVM_CMD_BYTE_PROG, 1'b1, 1'b1);
      wr(`NVM_ADDR_STATUS, 8'h30);
      m_acc = 0;
      m_pv = 0;
      st();
      run(`NVM_CMD_MASS_ERASE, 1'b0, 1'b0);
      @(posedge clk_sys) stop_entry <= 1'b1;
      @(posedge clk_sys) stop_entry <= 1'b0;
      m_acc = 1;
      m_irq |= 4;
      st();
      done(1'b0);
      run(`NVM_CMD_BURST_PROG, 1'b0, 1'b0);
      run(`NVM_CMD_BURST_PROG, 1'b0, 1'b0);
      done(1'b0);
      see(8'h25);
      st();
      done(1'b0);
      st();
      // Interrupt status register is read-only, then mask and clear
      wr(`NVM_ADDR_IRQ_STATUS, 8'h00);
      wr(`NVM_ADDR_IRQ_ENABLE, 8'h00);
      m_en = 0;
      st();
      wr(`NVM_ADDR_IRQ_ENABLE, 8'h07);
      m_en = 7;
      st();
      wr(`NVM_ADDR_IRQ_CLEAR, 8'h07);
      m_irq = 0;
      st();
      for (int k = 0; k < 5; k++) begin
         c = (k == 0) ? 8'hF0 : 8'($random(seed));
         wr(`NVM_ADDR_PROT, c);
         if ((c & ~m_prot[7:0]) == 0) m_prot = c;
         rd(`NVM_ADDR_PROT, m_prot);
         chk(prot_value, 8'(m_prot));
      end
      complete_run();
   end
endmodule
